/* core/status_indicator_loopback_test.sv */
// Panel indicator driver and per-channel loopback test controller
// How it works
// - Running normally: active lit, other system indicators dark, channel indicators may flash.
// - During configuration the system indicators mirror the soft switch selections.
// - Held in reset: every indicator lit at once.
// - Corrupt configuration memory reloads defaults and flashes the checksum indicator.
// - Self-test fail with checksum on, active off: bad cartridge; both off: RAM error.
// - Channels 1-4 on base, 5-10 first expansion, 11-16 second expansion.
// - Test commands rejected during a switched call or on permanent circuit channels.
// - Remote and system tests need the trunk up; local tests stay local.
// - A test on one channel leaves traffic on other channels untouched.
// - A break from the terminal ends the running test on that channel.
// - Accepted local echo test first returns an in-test-mode service message.
// - During local echo every received character goes straight back to the terminal.
`include "status_regs.svh"
`timescale 1ns/1ps
module status_indicator_loopback_test #(
	parameter int unsigned BLINK_HALF_CYCLES = `BLINK_HALF_CYC
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic reset_hold,
	input wire logic config_mode,
	input wire logic [7:0] soft_switch,
	input wire logic cmos_corrupt,
	input wire logic cold_start_clear,
	input wire logic cmos_fault,
	input wire logic cartridge_bad,
	input wire logic ram_error,
	input wire logic link_retransmit,
	input wire logic link_down,
	input wire logic data_discarding,
	input wire logic [7:0] buf_util,
	input wire logic trunk_up,
	input wire logic [15:0] chan_activity,
	input wire logic [15:0] chan_constant,
	input wire logic [15:0] svc_active,
	input wire logic [15:0] pvc_mode,
	input wire logic cmd_valid,
	input status_pkg::test_cmd_type cmd,
	output logic cmd_accept,
	output logic cmd_reject,
	output logic ext_test_start,
	output logic ext_test_stop,
	output status_pkg::test_cmd_type ext_test_cmd,
	output logic [15:0] loop_active,
	input wire logic rx_valid,
	output logic rx_ready,
	input status_pkg::rx_char_type rx_char,
	output logic fwd_valid,
	output status_pkg::rx_char_type fwd_char,
	output logic tx_valid,
	input wire logic tx_ready,
	output status_pkg::tx_char_type tx_char,
	output logic reload_defaults,
	output status_pkg::system_leds_type system_leds,
	output logic [3:0] base_chan_leds,
	output logic [5:0] exp1_chan_leds,
	output logic [5:0] exp2_chan_leds
);
	import status_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	logic blink;
	logic tick;
	panel_mode_type mode;
	logic [15:0] loop_reg, loop_next;
	logic [15:0] ext_reg, ext_next;
	logic [15:0] remote_reg, remote_next;
	logic [15:0] act_reg, act_next;
	logic [15:0] chan_led_reg, chan_led_next;
	logic svc_pend_reg, svc_pend_next;
	logic [3:0] svc_chan_reg, svc_chan_next;
	logic cold_reg, cold_next;
	logic accept_reg, accept_next, reject_reg, reject_next;
	logic start_reg, start_next, stop_reg, stop_next;
	test_cmd_type ext_cmd_reg, ext_cmd_next;
	logic fwd_valid_reg, fwd_valid_next;
	rx_char_type fwd_reg, fwd_next;
	logic reload_reg, reload_next;
	system_leds_type leds_reg, leds_next;
	logic busy, blocked, kind_ok, accept, rx_echo, rx_take, brk_hit;
	logic buf_in_valid, buf_in_ready;
	tx_char_type buf_in;

	blink_timer #(
		.HALF_CYCLES(BLINK_HALF_CYCLES)
	) u_blink (
		.clk(clk),
		.srst(srst),
		.blink(blink),
		.tick(tick)
	);

	echo_buffer u_buf (
		.clk(clk),
		.srst(srst),
		.in_valid(buf_in_valid),
		.in_ready(buf_in_ready),
		.in_data(buf_in),
		.out_valid(tx_valid),
		.out_ready(tx_ready),
		.out_data(tx_char)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Command checking and echo path
	always_comb begin
		busy = loop_reg[cmd.chan] | ext_reg[cmd.chan];
		blocked = svc_active[cmd.chan] | pvc_mode[cmd.chan];
		case (cmd.kind)
			TEST_LOCAL: kind_ok = !svc_pend_reg;
			TEST_TERMINAL: kind_ok = 1'b1;
			default: kind_ok = trunk_up;
		endcase
		accept = cmd_valid & !blocked & !busy & kind_ok;
		brk_hit = rx_valid & rx_char.brk;
		// Echoes wait while a service word owns the buffer input, or the echo would be lost
		rx_echo = rx_valid & !rx_char.brk & loop_reg[rx_char.chan];
		rx_ready = !rx_echo | (buf_in_ready & !svc_pend_reg);
		rx_take = rx_valid & rx_ready;
		buf_in_valid = svc_pend_reg | (rx_echo & rx_ready);
		if (svc_pend_reg) begin
			buf_in = '{chan: svc_chan_reg, data: `SVC_IN_TEST, service: 1'b1};
		end else begin
			buf_in = '{chan: rx_char.chan, data: rx_char.data, service: 1'b0};
		end
	end

	always_comb begin
		svc_pend_next = svc_pend_reg;
		svc_chan_next = svc_chan_reg;
		if (svc_pend_reg && buf_in_ready) begin
			svc_pend_next = 1'b0;
		end
		if (accept && cmd.kind == TEST_LOCAL) begin
			svc_pend_next = 1'b1;
			svc_chan_next = cmd.chan;
		end
		accept_next = accept;
		reject_next = cmd_valid & !accept;
		start_next = accept & (cmd.kind != TEST_LOCAL);
		stop_next = brk_hit & ext_reg[rx_char.chan];
		ext_cmd_next = ext_cmd_reg;
		if (start_next) begin
			ext_cmd_next = cmd;
		end else if (stop_next) begin
			ext_cmd_next.chan = rx_char.chan;
		end
		// Other channels pass through untouched while a test runs
		fwd_valid_next = rx_take & !rx_char.brk & !loop_reg[rx_char.chan] & !ext_reg[rx_char.chan];
		fwd_next = rx_take ? rx_char : fwd_reg;
		cold_next = cmos_corrupt | (cold_reg & !cold_start_clear);
		reload_next = cmos_corrupt;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Per-channel test state and activity indicators
	for (genvar i = 0; i < `NUM_CHAN; i++) begin : g_chan
		logic hit_cmd, hit_brk;
		assign hit_cmd = accept && (cmd.chan == 4'(i));
		assign hit_brk = brk_hit && (rx_char.chan == 4'(i));
		always_comb begin
			loop_next[i] = (loop_reg[i] & !hit_brk) | (hit_cmd & (cmd.kind == TEST_LOCAL));
			ext_next[i] = (ext_reg[i] & !hit_brk) | (hit_cmd & (cmd.kind != TEST_LOCAL));
			remote_next[i] = (remote_reg[i] & !hit_brk) | (hit_cmd & cmd.kind[1]);
			act_next[i] = chan_activity[i] | (act_reg[i] & !tick);
			if (mode == MODE_RESET) begin
				chan_led_next[i] = 1'b1;
			end else begin
				// Tick term keeps a burst that ends at a phase change visible
				chan_led_next[i] = chan_constant[i] | (act_reg[i] & (blink | tick));
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// System indicators
	always_comb begin
		if (srst || reset_hold) begin
			mode = MODE_RESET;
		end else if (config_mode) begin
			mode = MODE_CONFIG;
		end else begin
			mode = MODE_RUN;
		end
		leds_next = `LEDS_ALL_OFF;
		case (mode)
			MODE_RESET: leds_next = `LEDS_ALL_ON;
			MODE_CONFIG: leds_next = soft_switch;
			default: begin
				leds_next.active_led = !(cartridge_bad | ram_error);
				leds_next.channel_loop_led = (|remote_reg) & blink;
				leds_next.checksum_fault_led = cartridge_bad | (!ram_error & (cmos_fault | (cold_reg & blink)));
				leds_next.self_test_fail_led = cartridge_bad | ram_error;
				leds_next.link_fault_led = link_retransmit & blink;
				leds_next.buffer_overflow_led = data_discarding | ((buf_util > `BUF_UTIL_LIMIT) & blink);
				leds_next.link_down_led = link_down;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			loop_reg <= 16'h0000;
			ext_reg <= 16'h0000;
			remote_reg <= 16'h0000;
			act_reg <= 16'h0000;
			chan_led_reg <= 16'hFFFF;
			svc_pend_reg <= 1'b0;
			svc_chan_reg <= 4'h0;
			cold_reg <= 1'b0;
			accept_reg <= 1'b0;
			reject_reg <= 1'b0;
			start_reg <= 1'b0;
			stop_reg <= 1'b0;
			ext_cmd_reg <= '0;
			fwd_valid_reg <= 1'b0;
			fwd_reg <= '0;
			reload_reg <= 1'b0;
			leds_reg <= `LEDS_ALL_ON;
		end else begin
			loop_reg <= loop_next;
			ext_reg <= ext_next;
			remote_reg <= remote_next;
			act_reg <= act_next;
			chan_led_reg <= chan_led_next;
			svc_pend_reg <= svc_pend_next;
			svc_chan_reg <= svc_chan_next;
			cold_reg <= cold_next;
			accept_reg <= accept_next;
			reject_reg <= reject_next;
			start_reg <= start_next;
			stop_reg <= stop_next;
			ext_cmd_reg <= ext_cmd_next;
			fwd_valid_reg <= fwd_valid_next;
			fwd_reg <= fwd_next;
			reload_reg <= reload_next;
			leds_reg <= leds_next;
		end
	end

	assign cmd_accept = accept_reg;
	assign cmd_reject = reject_reg;
	assign ext_test_start = start_reg;
	assign ext_test_stop = stop_reg;
	assign ext_test_cmd = ext_cmd_reg;
	assign loop_active = loop_reg;
	assign fwd_valid = fwd_valid_reg;
	assign fwd_char = fwd_reg;
	assign reload_defaults = reload_reg;
	assign system_leds = leds_reg;
	assign base_chan_leds = chan_led_reg[`BASE_CHAN_FIRST +: `BASE_CHAN_COUNT];
	assign exp1_chan_leds = chan_led_reg[`EXP1_CHAN_FIRST +: `EXP1_CHAN_COUNT];
	assign exp2_chan_leds = chan_led_reg[`EXP2_CHAN_FIRST +: `EXP2_CHAN_COUNT];

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	logic run_clean;
	assign run_clean = !reset_hold & !config_mode & !cartridge_bad & !ram_error & !cmos_fault & !cold_reg
		& !link_retransmit & !link_down & !data_discarding & (buf_util <= `BUF_UTIL_LIMIT) & (remote_reg == 16'h0000);

	sequence local_accepted;
		cmd_valid && accept && cmd.kind == TEST_LOCAL;
	endsequence
	sequence service_queued;
		svc_pend_reg && buf_in_valid && buf_in.service && buf_in.data == `SVC_IN_TEST && !(rx_echo && rx_ready);
	endsequence

	chk_normal_leds: assert property (run_clean |=> system_leds == 8'h80)
		else $error("normal panel pattern wrong");
	chk_config_mirror: assert property (config_mode && !reset_hold |=> system_leds == $past(soft_switch))
		else $error("config leds do not mirror switches");
	chk_hold_all_on: assert property (reset_hold |=> system_leds == 8'hFF && chan_led_reg == 16'hFFFF)
		else $error("reset hold does not light all");
	chk_cold_reload: assert property (cmos_corrupt |=> reload_defaults && cold_reg ##1 cold_reg || $past(cold_start_clear))
		else $error("corruption did not reload defaults");
	chk_cartridge_leds: assert property (cartridge_bad && !reset_hold && !config_mode
		|=> system_leds.self_test_fail_led && system_leds.checksum_fault_led && !system_leds.active_led)
		else $error("bad cartridge pattern wrong");
	chk_ram_leds: assert property (ram_error && !cartridge_bad && !reset_hold && !config_mode
		|=> system_leds.self_test_fail_led && !system_leds.checksum_fault_led && !system_leds.active_led)
		else $error("ram error pattern wrong");
	chk_busy_reject: assert property (cmd_valid && (svc_active[cmd.chan] || pvc_mode[cmd.chan])
		|=> cmd_reject && !cmd_accept && !ext_test_start && (loop_reg & ~$past(loop_reg)) == 16'h0000)
		else $error("command taken during call or permanent circuit");
	chk_trunk_need: assert property (cmd_valid && cmd.kind[1] && !trunk_up |=> cmd_reject && !ext_test_start)
		else $error("network test started with trunk down");
	chk_break_ends: assert property (brk_hit && loop_reg[rx_char.chan] |=> !loop_reg[$past(rx_char.chan)])
		else $error("break did not end test");
	chk_service_first: assert property (local_accepted |=> service_queued ##0 svc_chan_reg == $past(cmd.chan))
		else $error("service message not first");
	chk_echo_same: assert property (rx_echo && rx_ready |-> buf_in_valid && !buf_in.service
		&& buf_in.data == rx_char.data && buf_in.chan == rx_char.chan)
		else $error("echoed character altered");
	chk_discard_steady: assert property ((data_discarding && !reset_hold && !config_mode) [*2]
		|=> system_leds.buffer_overflow_led)
		else $error("discard indicator not steady");
	chk_other_pass: assert property (rx_take && !rx_char.brk && !loop_reg[rx_char.chan] && !ext_reg[rx_char.chan]
		|=> fwd_valid && fwd_char == $past(rx_char))
		else $error("other channel traffic disturbed");
endmodule

/* core/status_regs.svh */
// Constants for the status indicator and loopback test block
`ifndef STATUS_REGS_SVH
`define STATUS_REGS_SVH

`define NUM_CHAN 16
`define BASE_CHAN_FIRST 0
`define BASE_CHAN_COUNT 4
`define EXP1_CHAN_FIRST 4
`define EXP1_CHAN_COUNT 6
`define EXP2_CHAN_FIRST 10
`define EXP2_CHAN_COUNT 6
`define BUF_UTIL_LIMIT 8'hA0
`define CLK_MHZ 100
`define BLINK_HALF_MS 250
`define BLINK_HALF_CYC (`BLINK_HALF_MS * 1000 * `CLK_MHZ)
`define SVC_IN_TEST 8'h01
`define LEDS_ALL_ON 8'hFF
`define LEDS_ALL_OFF 8'h00

`endif

/* core/status_pkg.sv */
// Types shared by the status indicator and loopback test block
package status_pkg;

	typedef enum logic [1:0] {TEST_LOCAL, TEST_TERMINAL, TEST_REMOTE, TEST_SYSTEM} test_kind_type;

	typedef enum logic [1:0] {MODE_RESET, MODE_CONFIG, MODE_RUN} panel_mode_type;

	typedef struct packed {
		test_kind_type kind;
		logic [3:0] chan;
	} test_cmd_type;

	typedef struct packed {
		logic [3:0] chan;
		logic [7:0] data;
		logic brk;
	} rx_char_type;

	typedef struct packed {
		logic [3:0] chan;
		logic [7:0] data;
		logic service;
	} tx_char_type;

	typedef struct packed {
		logic active_led;
		logic unused_led;
		logic channel_loop_led;
		logic checksum_fault_led;
		logic link_fault_led;
		logic buffer_overflow_led;
		logic self_test_fail_led;
		logic link_down_led;
	} system_leds_type;

endpackage

/* core/blink_timer.sv */
// Flash rate generator for the front panel indicators
`timescale 1ns/1ps
module blink_timer #(
	parameter int unsigned HALF_CYCLES = 25000000
) (
	input wire logic clk,
	input wire logic srst,
	output logic blink,
	output logic tick
);
	logic [31:0] count_reg;
	logic [31:0] count_next;
	logic blink_reg;
	logic blink_next;
	logic tick_reg;
	logic tick_next;

	always_comb begin
		count_next = count_reg + 32'h00000001;
		blink_next = blink_reg;
		tick_next = 1'b0;
		if (count_reg >= HALF_CYCLES - 1) begin
			count_next = 32'h00000000;
			blink_next = ~blink_reg;
			tick_next = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			count_reg <= 32'h00000000;
			blink_reg <= 1'b0;
			tick_reg <= 1'b0;
		end else begin
			count_reg <= count_next;
			blink_reg <= blink_next;
			tick_reg <= tick_next;
		end
	end

	assign blink = blink_reg;
	assign tick = tick_reg;
endmodule

/* core/echo_buffer.sv */
// Two-entry buffer on the path back to the terminal
`timescale 1ns/1ps
module echo_buffer (
	input wire logic clk,
	input wire logic srst,
	input wire logic in_valid,
	output logic in_ready,
	input status_pkg::tx_char_type in_data,
	output logic out_valid,
	input wire logic out_ready,
	output status_pkg::tx_char_type out_data
);
	import status_pkg::*;

	tx_char_type mem_reg [2];
	tx_char_type mem_next [2];
	logic wr_reg;
	logic wr_next;
	logic rd_reg;
	logic rd_next;
	logic [1:0] count_reg;
	logic [1:0] count_next;
	logic push;
	logic pop;

	assign in_ready = (count_reg != 2'h2);
	assign out_valid = (count_reg != 2'h0);
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	assign out_data = mem_reg[rd_reg];

	always_comb begin
		mem_next = mem_reg;
		wr_next = wr_reg;
		rd_next = rd_reg;
		count_next = count_reg;
		if (push) begin
			mem_next[wr_reg] = in_data;
			wr_next = ~wr_reg;
		end
		if (pop) begin
			rd_next = ~rd_reg;
		end
		if (push && !pop) begin
			count_next = count_reg + 2'h1;
		end else if (pop && !push) begin
			count_next = count_reg - 2'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			mem_reg[0] <= '0;
			mem_reg[1] <= '0;
			wr_reg <= 1'b0;
			rd_reg <= 1'b0;
			count_reg <= 2'h0;
		end else begin
			mem_reg <= mem_next;
			wr_reg <= wr_next;
			rd_reg <= rd_next;
			count_reg <= count_next;
		end
	end
endmodule

/* tb/terminal_model.sv */
// Terminal side model that takes the words sent back to the terminal
`timescale 1ns/1ps
module terminal_model (
	input wire logic clk,
	input wire logic [1:0] mode,
	output logic tx_ready
);
	////////////////////////////////////////////////////////////////
	// Mode 0 always ready, 1 stalls at random, 2 stalls throughout
	initial tx_ready = 1'b1;
	always @(posedge clk) begin
		tx_ready <= (mode == 2'h0) || (mode == 2'h1 && $urandom % 2 == 1);
	end
endmodule

/* tb/tb.sv */
// Self-checking bench for the panel indicator and loopback test block
`timescale 1ns/1ps
`include "status_regs.svh"
module tb;
	import status_pkg::*;
	logic clk, srst, reset_hold, config_mode, cmos_corrupt, cold_start_clear, cmos_fault, cartridge_bad, ram_error;
	logic link_retransmit, link_down, data_discarding, trunk_up, cmd_valid, rx_valid;
	logic [7:0] soft_switch, buf_util;
	logic [15:0] chan_activity, chan_constant, svc_active, pvc_mode;
	test_cmd_type cmd, ext_test_cmd;
	rx_char_type rx_char, fwd_char;
	tx_char_type tx_char;
	system_leds_type system_leds;
	logic cmd_accept, cmd_reject, ext_test_start, ext_test_stop, rx_ready, fwd_valid, tx_valid, tx_ready;
	logic reload_defaults, ok, seen;
	logic [15:0] loop_active;
	logic [3:0] base_chan_leds;
	logic [5:0] exp1_chan_leds, exp2_chan_leds;
	logic [1:0] mode;
	logic [12:0] tx_q[$], fwd_q[$];
	logic [2:0] cmd_q[$];
	int err_total, num_checks, n;
	logic [4:0] f_in [6] = '{5'h00, 5'h10, 5'h08, 5'h04, 5'h02, 5'h01};
	logic [7:0] f_mask [6] = '{8'hFF, 8'h10, 8'h92, 8'h92, 8'h01, 8'h04};
	logic [7:0] f_exp [6] = '{8'h80, 8'h10, 8'h12, 8'h02, 8'h01, 8'h04};

	status_indicator_loopback_test #(.BLINK_HALF_CYCLES(4)) status_indicator_loopback_test_inst (.clk(clk),
		.srst(srst), .reset_hold(reset_hold), .config_mode(config_mode), .soft_switch(soft_switch),
		.cmos_corrupt(cmos_corrupt), .cold_start_clear(cold_start_clear), .cmos_fault(cmos_fault),
		.cartridge_bad(cartridge_bad), .ram_error(ram_error), .link_retransmit(link_retransmit),
		.link_down(link_down), .data_discarding(data_discarding), .buf_util(buf_util), .trunk_up(trunk_up),
		.chan_activity(chan_activity), .chan_constant(chan_constant), .svc_active(svc_active),
		.pvc_mode(pvc_mode), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_accept(cmd_accept), .cmd_reject(cmd_reject),
		.ext_test_start(ext_test_start), .ext_test_stop(ext_test_stop), .ext_test_cmd(ext_test_cmd),
		.loop_active(loop_active), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_char(rx_char),
		.fwd_valid(fwd_valid), .fwd_char(fwd_char), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_char(tx_char),
		.reload_defaults(reload_defaults), .system_leds(system_leds), .base_chan_leds(base_chan_leds),
		.exp1_chan_leds(exp1_chan_leds), .exp2_chan_leds(exp2_chan_leds));

	terminal_model terminal_model_inst (.clk(clk), .mode(mode), .tx_ready(tx_ready));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////
	task cmp(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask

	task end_of_test;
		if (err_total == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task wait_n(input int k);
		repeat (k) @(negedge clk);
	endtask

	task send_cmd(input logic [1:0] k, input logic [3:0] c, input logic [2:0] exp);
		@(negedge clk);
		cmd_valid = 1'b1;
		cmd = test_cmd_type'({k, c});
		cmd_q.push_back(exp);
		@(negedge clk);
		cmd_valid = 1'b0;
		cmd = ~cmd;
	endtask

	// Destination 0 dropped, 1 echoed back, 2 passed on
	task send_rx(input logic [3:0] c, input logic [7:0] d, input logic b, input int lim, input logic [1:0] dst);
		@(negedge clk);
		rx_valid = 1'b1;
		rx_char = rx_char_type'({c, d, b});
		ok = 1'b0;
		for (int i = 0; i < lim && !ok; i++) begin
			#1;
			if (rx_ready === 1'b1) begin
				ok = 1'b1;
				if (dst == 2'h1) tx_q.push_back({c, d, 1'b0});
				if (dst == 2'h2) fwd_q.push_back({c, d, b});
			end
			@(negedge clk);
		end
		rx_valid = 1'b0;
		rx_char = ~rx_char;
	endtask

	task see_both(input int b);
		logic [1:0] hit;
		hit = 2'h0;
		repeat (24) begin
			@(negedge clk);
			if (system_leds[b] === 1'b1) hit[1] = 1'b1;
			if (system_leds[b] === 1'b0) hit[0] = 1'b1;
		end
		cmp(hit, 2'h3);
	endtask

	task drain;
		for (int i = 0; i < 300 && (tx_q.size() + fwd_q.size() + cmd_q.size()) > 0; i++) @(negedge clk);
		cmp(tx_q.size() + fwd_q.size() + cmd_q.size(), 0);
	endtask

	////////////////////////////////////////////////////////////////
	// Result watcher: oldest note against each result that appears
	always @(posedge clk) begin
		if (srst === 1'b0) begin
			if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
				if (tx_q.size() == 0) cmp(tx_char, 13'h1FFF);
				else cmp(tx_char, tx_q.pop_front());
			end
			if (fwd_valid === 1'b1) begin
				if (fwd_q.size() == 0) cmp(fwd_char, 13'h1FFF);
				else cmp(fwd_char, fwd_q.pop_front());
			end
			if (cmd_accept === 1'b1 || cmd_reject === 1'b1) begin
				if (cmd_q.size() == 0) cmp(3'h7, 3'h0);
				else cmp({cmd_accept, cmd_reject, ext_test_start}, cmd_q.pop_front());
			end
		end
	end

	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		end_of_test();
	end

	initial begin
		{srst, reset_hold, config_mode, cmos_corrupt, cold_start_clear, cmos_fault, cartridge_bad} = 7'h41;
		{ram_error, link_retransmit, link_down, data_discarding, trunk_up, cmd_valid, rx_valid} = 7'h00;
		{soft_switch, buf_util, chan_activity, chan_constant, svc_active, pvc_mode} = 80'h0;
		cmd = test_cmd_type'(6'h0);
		rx_char = rx_char_type'(13'h0);
		mode = 2'h0;
		err_total = 0;
		num_checks = 0;
		void'($urandom(32'hf68d4b2f));
		wait_n(4);
		cmp({system_leds, exp2_chan_leds, exp1_chan_leds, base_chan_leds}, 24'hFFFFFF);
		srst = 1'b0;
		wait_n(3);
		config_mode = 1'b1;
		repeat (3) begin
			soft_switch = 8'($urandom);
			wait_n(3);
			cmp(system_leds, soft_switch);
		end
		config_mode = 1'b0;
		for (int i = 0; i < 6; i++) begin
			{cmos_fault, cartridge_bad, ram_error, link_down, data_discarding} = f_in[i];
			wait_n(3);
			cmp(system_leds & f_mask[i], f_exp[i]);
		end
		data_discarding = 1'b0;
		reset_hold = 1'b1;
		wait_n(3);
		cmp({system_leds, exp2_chan_leds, exp1_chan_leds, base_chan_leds}, 24'hFFFFFF);
		reset_hold = 1'b0;
		for (int i = 0; i < 16; i++) begin
			chan_constant = 16'h1 << i;
			wait_n(3);
			cmp({exp2_chan_leds, exp1_chan_leds, base_chan_leds}, chan_constant);
		end
		chan_constant = 16'h0;
		wait_n(3);
		chan_activity[11] = 1'b1;
		@(negedge clk);
		chan_activity[11] = 1'b0;
		seen = 1'b0;
		repeat (16) begin
			@(negedge clk);
			if (exp2_chan_leds[1] === 1'b1) seen = 1'b1;
		end
		cmp(seen, 1'b1);
		wait_n(30);
		cmp({exp2_chan_leds, exp1_chan_leds, base_chan_leds}, 16'h0);
		buf_util = 8'hA0;
		wait_n(3);
		cmp(system_leds.buffer_overflow_led, 1'b0);
		buf_util = 8'hA1;
		see_both(2);
		buf_util = 8'h00;
		link_retransmit = 1'b1;
		see_both(3);
		link_retransmit = 1'b0;
		@(negedge clk);
		cmos_corrupt = 1'b1;
		@(negedge clk);
		cmos_corrupt = 1'b0;
		cmp(reload_defaults, 1'b1);
		see_both(4);
		cold_start_clear = 1'b1;
		@(negedge clk);
		cold_start_clear = 1'b0;
		wait_n(3);
		cmp(system_leds.checksum_fault_led, 1'b0);
		svc_active[1] = 1'b1;
		send_cmd(2'h0, 4'h1, 3'h2);
		svc_active[1] = 1'b0;
		pvc_mode[1] = 1'b1;
		for (int k = 0; k < 4; k++) send_cmd(k[1:0], 4'h1, 3'h2);
		pvc_mode[1] = 1'b0;
		send_cmd(2'h2, 4'h3, 3'h2);
		send_cmd(2'h3, 4'h3, 3'h2);
		trunk_up = 1'b1;
		send_cmd(2'h2, 4'h3, 3'h5);
		see_both(5);
		send_cmd(2'h1, 4'h4, 3'h5);
		send_cmd(2'h3, 4'h7, 3'h5);
		tx_q.push_back({4'h2, `SVC_IN_TEST, 1'b1});
		mode = 2'h1;
		send_cmd(2'h0, 4'h2, 3'h4);
		send_cmd(2'h0, 4'h2, 3'h2);
		cmp(loop_active, 16'h0004);
		repeat (6) begin
			send_rx(4'h2, $urandom, 1'b0, 50, 2'h1);
			cmp(ok, 1'b1);
			send_rx(4'h6, $urandom, 1'b0, 50, 2'h2);
			cmp(ok, 1'b1);
		end
		drain();
		mode = 2'h2;
		n = 0;
		ok = 1'b1;
		while (ok && n < 8) begin
			send_rx(4'h2, $urandom, 1'b0, 3, 2'h1);
			if (ok) n++;
		end
		cmp(n, 2);
		mode = 2'h0;
		send_rx(4'h2, $urandom, 1'b0, 50, 2'h1);
		cmp(ok, 1'b1);
		drain();
		// Break from the terminal ends the echo test
		send_rx(4'h2, 8'h00, 1'b1, 50, 2'h0);
		wait_n(3);
		cmp(loop_active[2], 1'b0);
		send_rx(4'h2, 8'h5A, 1'b0, 50, 2'h2);
		send_rx(4'h3, 8'h00, 1'b1, 50, 2'h0);
		seen = 1'b0;
		for (int i = 0; i < 5; i++) begin
			if (ext_test_stop === 1'b1) begin
				seen = 1'b1;
				cmp(ext_test_cmd.chan, 4'h3);
			end
			@(negedge clk);
		end
		cmp(seen, 1'b1);
		drain();
		end_of_test();
	end
endmodule
